// [rtl/acc_comparator_ctrl.sv]
// Purpose: Register, sync and event logic around an analog comparator
// Assumes: hclk 100 MHz, raw comparator and pin levels are asynchronous
// Notes: Zero-wait AHB-Lite slave, always OKAY
//
// Overview of operation
// - Result one when positive input exceeds negative
// - Mux on, converter off: channel picks negative
// - Mux enable at bit 6, control B
// - Bandgap select feeds reference to positive input
// - Disable bit powers comparator off, anytime
// - Result bit synchronized, lags one to two
// - Selected output event sets the flag
// - Request needs flag, enable and global enable
// - Vector execution clears the flag
// - Writing one clears flag, zero keeps
// - Modes: toggle, reserved, falling, rising
// - Capture route passes output to timer
// - Control status at 0x30, layout, zero reset
// - Input disable bits force pin reads zero
//
// The AHB-Lite interface to the registers was decided locally.
module acc_comparator_ctrl
   import acc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic comparator_raw,
   input wire logic positive_pin_level,
   input wire logic negative_pin_level,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output acc_analog_s analog_sel,
   output logic comparator_irq,
   output logic capture_out,
   output logic positive_pin_input_off,
   output logic negative_pin_input_off
);
   logic [7:0] ctrl_r;
   logic [7:0] conv_b_r;
   logic [7:0] din_off_r;
   logic [7:0] conv_a_r;
   logic [7:0] chan_r;
   logic flag_r;
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic [1:0] pin_s1_r;
   logic [1:0] pin_s2_r;
   acc_bus_e bus_r;
   logic wr_pend_r;
   logic [7:0] addr_r;
   logic event_hit;
   logic flag_clr_wr;
   logic take;
   logic [31:0] rd_nxt;
   logic irq_nxt;
   acc_analog_s sel_nxt;

   // Address phase capture
   assign take = hsel && hready && (htrans == ACC_HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_r <= ACC_ST_IDLE;
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         case (bus_r)
            ACC_ST_IDLE: begin
               if (take) begin
                  bus_r <= ACC_ST_DATA;
               end
            end
            ACC_ST_DATA: begin
               if (!take) begin
                  bus_r <= ACC_ST_IDLE;
               end
            end
            default: bus_r <= ACC_ST_IDLE;
         endcase
         wr_pend_r <= take && hwrite;
         if (take) begin
            addr_r <= haddr[7:0];
         end
      end
   end

   assign flag_clr_wr = wr_pend_r && (addr_r == ACC_OFS_CTRL_STATUS)
      && hwdata[ACC_B_FLAG];

   // Control register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= ACC_RST_BYTE;
         conv_b_r <= ACC_RST_BYTE;
         din_off_r <= ACC_RST_BYTE;
         conv_a_r <= ACC_RST_BYTE;
         chan_r <= ACC_RST_BYTE;
      end else if (wr_pend_r) begin
         if (addr_r == ACC_OFS_CTRL_STATUS) begin
            ctrl_r <= hwdata[7:0];
         end else if (addr_r == ACC_OFS_CONV_CTRL_B) begin
            conv_b_r <= hwdata[7:0];
         end else if (addr_r == ACC_OFS_DIN_DISABLE) begin
            din_off_r <= hwdata[7:0];
         end else if (addr_r == ACC_OFS_CONV_CTRL_A) begin
            conv_a_r <= hwdata[7:0];
         end else if (addr_r == ACC_OFS_CHANNEL) begin
            chan_r <= hwdata[7:0];
         end
      end
   end

   // Comparator result and pin synchronizers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
         pin_s1_r <= 2'b00;
         pin_s2_r <= 2'b00;
      end else begin
         sync1_r <= comparator_raw;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         pin_s1_r <= {negative_pin_level, positive_pin_level};
         pin_s2_r <= pin_s1_r;
      end
   end

   // Event selection
   always_comb begin
      case (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO])
         ACC_MODE_TOGGLE: event_hit = sync2_r ^ prev_r;
         ACC_MODE_FALL: event_hit = prev_r && !sync2_r;
         ACC_MODE_RISE: event_hit = !prev_r && sync2_r;
         default: event_hit = 1'b0;
      endcase
   end

   // Flag: set wins over both clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= 1'b0;
      end else if (event_hit) begin
         flag_r <= 1'b1;
      end else if (flag_clr_wr || irq_vector_ack) begin
         flag_r <= 1'b0;
      end
   end

   // Registered outputs
   always_comb begin
      irq_nxt = flag_r && ctrl_r[ACC_B_IRQ_EN] && global_irq_enable;
      sel_nxt.power_off = ctrl_r[ACC_B_DISABLE];
      sel_nxt.bandgap_select = ctrl_r[ACC_B_BANDGAP];
      sel_nxt.neg_use_channel = conv_b_r[ACC_B_NEG_MUX_EN]
         && !conv_a_r[ACC_B_CONV_EN];
      sel_nxt.channel_select = chan_r[2:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comparator_irq <= 1'b0;
         analog_sel <= '0;
         capture_out <= 1'b0;
         positive_pin_input_off <= 1'b0;
         negative_pin_input_off <= 1'b0;
      end else begin
         comparator_irq <= irq_nxt;
         analog_sel <= sel_nxt;
         capture_out <= ctrl_r[ACC_B_CAPTURE] && sync2_r;
         positive_pin_input_off <= din_off_r[ACC_B_POS_OFF];
         negative_pin_input_off <= din_off_r[ACC_B_NEG_OFF];
      end
   end

   // Read data, decoded at the address phase
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (haddr[7:0] == ACC_OFS_CTRL_STATUS) begin
         rd_nxt[7:0] = ctrl_r;
         rd_nxt[ACC_B_RESULT] = sync2_r;
         rd_nxt[ACC_B_FLAG] = flag_r;
      end else if (haddr[7:0] == ACC_OFS_CONV_CTRL_B) begin
         rd_nxt[7:0] = conv_b_r;
      end else if (haddr[7:0] == ACC_OFS_DIN_DISABLE) begin
         rd_nxt[7:0] = din_off_r;
      end else if (haddr[7:0] == ACC_OFS_CONV_CTRL_A) begin
         rd_nxt[7:0] = conv_a_r;
      end else if (haddr[7:0] == ACC_OFS_CHANNEL) begin
         rd_nxt[7:0] = chan_r;
      end else if (haddr[7:0] == ACC_OFS_PIN_READ) begin
         rd_nxt[1:0] = pin_s2_r & ~din_off_r[1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         if (take && !hwrite) begin
            hrdata <= rd_nxt;
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Checks
   chk_result_sync_lag: assert property (@(posedge hclk) disable iff (!hresetn)
      ##2 (sync2_r == $past(comparator_raw, 2)))
      else $error("result bit not two cycles behind raw");
   chk_flag_on_event: assert property (@(posedge hclk) disable iff (!hresetn)
      event_hit |=> flag_r)
      else $error("event did not set flag");
   chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      comparator_irq |-> $past(flag_r && ctrl_r[ACC_B_IRQ_EN] && global_irq_enable))
      else $error("request without flag and enables");
   chk_vector_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (irq_vector_ack && !event_hit) |=> !flag_r)
      else $error("vector did not clear flag");
   chk_write_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && addr_r == ACC_OFS_CTRL_STATUS && !hwdata[ACC_B_FLAG]
       && !irq_vector_ack && flag_r) |=> flag_r)
      else $error("write of zero cleared flag");
   chk_reserved_mode: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO] == ACC_MODE_RSVD && !flag_r) |=> !flag_r)
      else $error("reserved mode set the flag");
   chk_rise_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO] == ACC_MODE_RISE && $fell(sync2_r))
      |-> !event_hit)
      else $error("falling edge hit in rising mode");
   chk_capture_route: assert property (@(posedge hclk) disable iff (!hresetn)
      !ctrl_r[ACC_B_CAPTURE] |=> !capture_out)
      else $error("capture driven while route off");
   chk_neg_mux: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_a_r[ACC_B_CONV_EN] |=> !analog_sel.neg_use_channel)
      else $error("channel used while converter on");
   chk_pin_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[7:0] == ACC_OFS_PIN_READ && din_off_r[0])
      |=> !hrdata[0])
      else $error("disabled pin read nonzero");

   // Event decode per mode
   chk_toggle_hit: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO] == ACC_MODE_TOGGLE && $changed(sync2_r))
      |-> event_hit)
      else $error("output change missed in toggle mode");
   chk_rise_hit: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO] == ACC_MODE_RISE && $rose(sync2_r))
      |-> event_hit)
      else $error("rising edge missed in rising mode");
   chk_fall_hit: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO] == ACC_MODE_FALL && $fell(sync2_r))
      |-> event_hit)
      else $error("falling edge missed in falling mode");
   chk_fall_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_r[ACC_B_MODE_HI:ACC_B_MODE_LO] == ACC_MODE_FALL && $rose(sync2_r))
      |-> !event_hit)
      else $error("rising edge hit in falling mode");

   // Flag, register and output follow-up
   chk_write_one_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (flag_clr_wr && !event_hit) |=> !flag_r)
      else $error("write of one kept flag");
   chk_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && addr_r == ACC_OFS_CTRL_STATUS) |=> (ctrl_r == $past(hwdata[7:0])))
      else $error("control write not stored");
   chk_data_phase: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_r |-> (bus_r == ACC_ST_DATA))
      else $error("write pending outside data phase");
   chk_mux_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !conv_b_r[ACC_B_NEG_MUX_EN] |=> !analog_sel.neg_use_channel)
      else $error("channel used while mux enable clear");
   chk_power_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      analog_sel.power_off == $past(ctrl_r[ACC_B_DISABLE]))
      else $error("power off not following disable bit");
   chk_bandgap_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      analog_sel.bandgap_select == $past(ctrl_r[ACC_B_BANDGAP]))
      else $error("bandgap select not following bit");
   chk_irq_block: assert property (@(posedge hclk) disable iff (!hresetn)
      !ctrl_r[ACC_B_IRQ_EN] |=> !comparator_irq)
      else $error("request while enable clear");
   chk_result_read: assert property (@(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[7:0] == ACC_OFS_CTRL_STATUS)
      |=> (hrdata[ACC_B_RESULT] == $past(sync2_r)))
      else $error("result bit read not synced value");
   chk_pos_buf_off: assert property (@(posedge hclk) disable iff (!hresetn)
      positive_pin_input_off == $past(din_off_r[ACC_B_POS_OFF]))
      else $error("positive buffer off not following bit");
   chk_neg_buf_off: assert property (@(posedge hclk) disable iff (!hresetn)
      negative_pin_input_off == $past(din_off_r[ACC_B_NEG_OFF]))
      else $error("negative buffer off not following bit");
endmodule

// [rtl/acc_pkg.sv]
// Purpose: Constants and types for the analog comparator control block
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package acc_pkg;
   localparam logic [7:0] ACC_OFS_CTRL_STATUS = 8'h30;
   localparam logic [7:0] ACC_OFS_CONV_CTRL_B = 8'h34;
   localparam logic [7:0] ACC_OFS_DIN_DISABLE = 8'h38;
   localparam logic [7:0] ACC_OFS_CONV_CTRL_A = 8'h3c;
   localparam logic [7:0] ACC_OFS_CHANNEL = 8'h40;
   localparam logic [7:0] ACC_OFS_PIN_READ = 8'h44;
   // Control/status, converter control B and A, and input disable bit positions
   localparam int ACC_B_DISABLE = 7;
   localparam int ACC_B_BANDGAP = 6;
   localparam int ACC_B_RESULT = 5;
   localparam int ACC_B_FLAG = 4;
   localparam int ACC_B_IRQ_EN = 3;
   localparam int ACC_B_CAPTURE = 2;
   localparam int ACC_B_MODE_HI = 1;
   localparam int ACC_B_MODE_LO = 0;
   localparam int ACC_B_NEG_MUX_EN = 6;
   localparam int ACC_B_CONV_EN = 7;
   localparam int ACC_B_NEG_OFF = 1;
   localparam int ACC_B_POS_OFF = 0;
   localparam logic [7:0] ACC_RST_BYTE = 8'h00;
   localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
   localparam logic [1:0] ACC_MODE_RSVD = 2'h1;
   localparam logic [1:0] ACC_MODE_FALL = 2'h2;
   localparam logic [1:0] ACC_MODE_RISE = 2'h3;
   localparam logic [1:0] ACC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] ACC_HSIZE_WORD = 3'h2;

   // Analog selection handed to the comparator core
   typedef struct packed {
      logic power_off;
      logic bandgap_select;
      logic neg_use_channel;
      logic [2:0] channel_select;
   } acc_analog_s;

   typedef enum logic [1:0] {
      ACC_ST_IDLE = 2'b01,
      ACC_ST_DATA = 2'b10
   } acc_bus_e;
endpackage

// [verification/acc_analog_model.sv]
// Purpose: Behavioural comparator core beside the control block
// Assumes: Voltages given as unsigned 8-bit codes
// Notes: A powered-off core drives its result low
module acc_analog_model
   import acc_pkg::*;
(
   input wire acc_analog_s analog_sel,
   input wire logic [7:0] pos_v,
   input wire logic [7:0] neg_v,
   input wire logic [7:0] bg_v,
   input wire logic [63:0] chan_v,
   output logic comparator_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] p;
   logic [7:0] n;
   assign p = analog_sel.bandgap_select ? bg_v : pos_v;
   assign n = analog_sel.neg_use_channel ? chan_v[analog_sel.channel_select*8 +: 8] : neg_v;
   assign comparator_raw = !analog_sel.power_off && (p > n);
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench for the comparator control block
// Assumes: Zero-wait AHB-Lite slave, pipelined single word transfers
// Notes: Software ordering kept by the stimulus
module tb
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, gie, ack, ppin, npin;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, raw, irq, cap, poff, noff;
   wire logic hready;
   acc_analog_s sel;
   logic [7:0] pos_v, neg_v;
   int fails, checked;
   assign hready = hreadyout;
   acc_comparator_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comparator_raw(raw),
      .positive_pin_level(ppin), .negative_pin_level(npin), .global_irq_enable(gie),
      .irq_vector_ack(ack), .analog_sel(sel), .comparator_irq(irq), .capture_out(cap),
      .positive_pin_input_off(poff), .negative_pin_input_off(noff));
   acc_analog_model core (.analog_sel(sel), .pos_v(pos_v), .neg_v(neg_v), .bg_v(8'h96),
      .chan_v(64'h0), .comparator_raw(raw));
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= ACC_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdv = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rdv);
   endtask
   task automatic t_reset;
      for (int a = 32'h30; a <= 32'h44; a += 4) rdc("reset value", 8'(a), 32'h0);
      rdc("unmapped", 8'h50, 32'h0);
   endtask
   task automatic t_pins;
      ppin <= 1'b1;
      npin <= 1'b1;
      cyc(4);
      rdc("pins", 8'h44, 32'h3);
      bus(1'b1, 8'h38, 32'h1);
      cyc(2);
      rdc("pos off", 8'h44, 32'h2);
      chk("pos buf", 32'h1, 32'(poff));
      bus(1'b1, 8'h38, 32'h2);
      cyc(2);
      rdc("neg off", 8'h44, 32'h1);
      chk("neg buf", 32'h1, 32'(noff));
   endtask
   task automatic t_mux;
      bus(1'b1, 8'h34, 32'h40);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'h40, 32'(i));
         cyc(2);
         chk("channel", 32'h8 | 32'(i), 32'(sel));
      end
      bus(1'b1, 8'h3c, 32'h80);
      cyc(2);
      chk("conv on", 32'h7, 32'(sel));
      bus(1'b1, 8'h3c, 32'h0);
      bus(1'b1, 8'h34, 32'h0);
      cyc(2);
      chk("mux off", 32'h7, 32'(sel));
      bus(1'b1, 8'h30, 32'hc0);
      cyc(2);
      chk("pwr bg", 32'h37, 32'(sel));
      bus(1'b1, 8'h30, 32'h10);
   endtask
   task automatic t_events;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 8'h30, 32'h10 | 32'(m));
         pos_v <= 8'hc8;
         cyc(6);
         rdc("rise", 8'h30, 32'h20 | 32'(m) | ((m == 0 || m == 3) ? 32'h10 : 0));
         bus(1'b1, 8'h30, 32'h10 | 32'(m));
         rdc("clear", 8'h30, 32'h20 | 32'(m));
         pos_v <= 8'h32;
         cyc(6);
         rdc("fall", 8'h30, 32'(m) | ((m == 0 || m == 2) ? 32'h10 : 0));
         bus(1'b1, 8'h30, 32'(m));
         rdc("keep", 8'h30, 32'(m) | ((m == 0 || m == 2) ? 32'h10 : 0));
      end
   endtask
   task automatic t_irq;
      pos_v <= 8'hc8;
      cyc(6);
      bus(1'b1, 8'h30, 32'h0b);
      cyc(3);
      chk("irq masked", 32'h0, 32'(irq));
      gie <= 1'b1;
      cyc(3);
      chk("irq on", 32'h1, 32'(irq));
      bus(1'b1, 8'h30, 32'h03);
      cyc(3);
      chk("irq off", 32'h0, 32'(irq));
      bus(1'b1, 8'h30, 32'h0b);
      ack <= 1'b1;
      cyc(1);
      ack <= 1'b0;
      cyc(3);
      chk("irq ack", 32'h0, 32'(irq));
      rdc("ack flag", 8'h30, 32'h2b);
      bus(1'b1, 8'h30, 32'h03);
   endtask
   task automatic t_cap;
      pos_v <= 8'h32;
      bus(1'b1, 8'h30, 32'h14);
      pos_v <= 8'hc8;
      cyc(6);
      chk("capture", 32'h1, 32'(cap));
      bus(1'b1, 8'h30, 32'h10);
      cyc(3);
      chk("capture off", 32'h0, 32'(cap));
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      final_report();
   end
   initial begin
      {hresetn, hsel, hwrite, gie, ack, ppin, npin} = '0;
      haddr = '0;
      hwdata = '0;
      htrans = '0;
      hsize = ACC_HSIZE_WORD;
      pos_v = 8'h32;
      neg_v = 8'h64;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_pins();
      t_mux();
      t_events();
      t_irq();
      t_cap();
      final_report();
   end
endmodule
